// ### src/twi_arb_master.sv
// Multi-master controller with collision detection and bus-free tracking
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
// Behaviour
// RQ1 - Released high bit read low: collision
// RQ2 - Collision sets flag, port goes idle
// RQ3 - SDA changes only while SCL low
// RQ4 - Collision in transmit clears buffer full
// RQ5 - Collision aborts sequence, clears request bit
// RQ6 - Software restarts only with Start, bus free
// RQ7 - Keep watching; Stop sets event flag
// RQ8 - New buffer write starts at bit one
// RQ9 - Bus free: stop seen, or both clear
// RQ10 - Start with line low: abort, collision
// RQ11 - Start: released lines, SDA high loads count
// RQ12 - SCL low in first count: collision
// RQ13 - SDA low in first count: pull early
// RQ14 - Second count then SCL pulled low
// RQ15 - Simultaneous Starts arbitrate in address
// RQ16 - Check all arbitration phases
// RQ17 - Reset disables port, ends transfer
// RQ18 - Start/Stop seen cleared on reset, disable
// RQ19 - Open-drain drive only
// RQ20 - Collision flag sticky until software clears
module twi_arb_master
(
    input wire logic core_clk,
    input wire logic arst_n,
    twi_bus_if.ctl bus,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import arb_pkg::*;
    typedef enum {S_IDLE, S_ST1, S_ST2, S_BITLO, S_BITHI, S_RSLO, S_RSHI,
        S_SPLO, S_SPHI, S_SPEND, S_AKLO, S_AKHI} state_t;

    state_t st_r, st_nxt;
    logic [2:0] scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;
    logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt;
    logic [7:0] cnt_r, cnt_nxt, ctl_r, ctl_nxt, tx_r, tx_nxt, rx_r, rx_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic sda_r, sda_nxt, scl_r, scl_nxt;
    logic bf_r, bf_nxt, s_r, s_nxt, p_r, p_nxt, bcl_r, bcl_nxt, evt_r, evt_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic ack_r, ack_nxt;
    logic en, cnt_done, collide, start_seen, stop_seen, wr, rd, bus_free;

    assign en = ctl_r[CTL_EN];
    assign cnt_done = (cnt_r == BAUD_ZERO);
    // Writes land only at the edge where waitrequest is seen low
    assign wr = avs_write & ack_r;
    assign rd = avs_read & ack_r == 1'b0;
    assign start_seen = scl_f_r & sda_f_r & ~sda_f_nxt;
    assign stop_seen = scl_f_r & ~sda_f_r & sda_f_nxt;
    // RQ9 bus free test
    assign bus_free = p_r | (~s_r & ~p_r);

    // Three-stage pin filter; the first stage feeds only the second
    always_comb
    begin
        scl_s_nxt = {scl_s_r[1:0], bus.scl_i};
        sda_s_nxt = {sda_s_r[1:0], bus.sda_i};
        scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
        sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
    end

    // Main sequencer; every collision path ends in S_IDLE with lines released
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_done ? BAUD_ZERO : cnt_r - 8'h01;
        ctl_nxt = ctl_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        bit_nxt = bit_r;
        sda_nxt = sda_r;
        scl_nxt = scl_r;
        bf_nxt = bf_r;
        collide = 1'b0;
        case (st_r)
            S_IDLE:
            begin
                // Lines keep their level: after a Start or a byte SCL stays low,
                // since letting it go here would clock a stray bit into the receiver
                // RQ6 software starts
                if (en && ctl_r[CTL_START])
                begin
                    // RQ10 lines already low
                    if (!sda_f_r || !scl_f_r)
                        collide = 1'b1;
                    else
                    begin
                        // RQ11 load baud count
                        cnt_nxt = BAUD_RELOAD;
                        st_nxt = S_ST1;
                    end
                end
                else if (en && ctl_r[CTL_RSTART])
                begin
                    scl_nxt = 1'b0;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_RSLO;
                end
                else if (en && ctl_r[CTL_STOP])
                begin
                    scl_nxt = 1'b0;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_SPLO;
                end
                else if (en && ctl_r[CTL_ACK])
                begin
                    scl_nxt = 1'b0;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_AKLO;
                end
                else if (en && bf_r)
                begin
                    // RQ8 first data bit
                    bit_nxt = 4'h0;
                    scl_nxt = 1'b0;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_BITLO;
                end
            end
            S_ST1:
            begin
                // RQ13 early SDA assert
                if (!sda_f_r)
                begin
                    sda_nxt = 1'b0;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_ST2;
                end
                // RQ12 SCL low collision
                else if (!scl_f_r)
                    collide = 1'b1;
                // RQ14 pull SDA, reload
                else if (cnt_done)
                begin
                    sda_nxt = 1'b0;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_ST2;
                end
            end
            S_ST2:
            begin
                // RQ15 no collision here
                if (cnt_done)
                begin
                    scl_nxt = 1'b0;
                    ctl_nxt[CTL_START] = 1'b0;
                    ctl_nxt[CTL_RSTART] = 1'b0;
                    st_nxt = S_IDLE;
                end
            end
            S_BITLO:
            begin
                // RQ3 change on low
                if (cnt_done)
                begin
                    scl_nxt = 1'b1;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_BITHI;
                end
                else if (cnt_r == BAUD_RELOAD - 8'h01)
                    sda_nxt = (bit_r == 4'h8) ? 1'b1 : tx_r[7];
            end
            S_BITHI:
            begin
                // RQ1 compare released bit
                // RQ16 address and data
                if (scl_f_r && sda_r && !sda_f_r && bit_r != 4'h8)
                    collide = 1'b1;
                else if (cnt_done)
                begin
                    scl_nxt = 1'b0;
                    cnt_nxt = BAUD_RELOAD;
                    rx_nxt = {rx_r[6:0], sda_f_r};
                    tx_nxt = {tx_r[6:0], 1'b0};
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == 4'h8)
                    begin
                        bf_nxt = 1'b0;
                        st_nxt = S_IDLE;
                    end
                    else
                        st_nxt = S_BITLO;
                end
            end
            S_RSLO:
            begin
                sda_nxt = 1'b1;
                if (cnt_done)
                begin
                    scl_nxt = 1'b1;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_RSHI;
                end
            end
            S_RSHI:
            begin
                // RQ16 repeated start
                if (!sda_f_r && cnt_r != BAUD_RELOAD)
                    collide = 1'b1;
                else if (cnt_done)
                begin
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_ST1;
                end
            end
            S_SPLO:
            begin
                sda_nxt = 1'b0;
                if (cnt_done)
                begin
                    scl_nxt = 1'b1;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_SPHI;
                end
            end
            S_SPHI:
            begin
                if (cnt_done)
                begin
                    sda_nxt = 1'b1;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_SPEND;
                end
            end
            S_SPEND:
            begin
                // RQ16 stop arbitration
                // Wait out the pin filter before reading back the released SDA
                if (!sda_f_r && cnt_r < BAUD_RELOAD - FILT_SETTLE)
                    collide = 1'b1;
                else if (cnt_done)
                begin
                    ctl_nxt[CTL_STOP] = 1'b0;
                    st_nxt = S_IDLE;
                end
            end
            S_AKLO:
            begin
                sda_nxt = ctl_r[CTL_ACKDT];
                if (cnt_done)
                begin
                    scl_nxt = 1'b1;
                    cnt_nxt = BAUD_RELOAD;
                    st_nxt = S_AKHI;
                end
            end
            S_AKHI:
            begin
                // RQ16 acknowledge phase
                if (scl_f_r && sda_r && !sda_f_r)
                    collide = 1'b1;
                else if (cnt_done)
                begin
                    scl_nxt = 1'b0;
                    ctl_nxt[CTL_ACK] = 1'b0;
                    st_nxt = S_IDLE;
                end
            end
            default:
                st_nxt = S_IDLE;
        endcase
        // RQ2 idle on collision
        // RQ4 release, clear full
        // RQ5 clear request bits
        if (collide)
        begin
            st_nxt = S_IDLE;
            sda_nxt = 1'b1;
            scl_nxt = 1'b1;
            bf_nxt = 1'b0;
            ctl_nxt[3:0] = 4'h0;
        end
        // Register writes; requests from software land after the sequencer
        if (wr && avs_address == OFS_CTRL)
            ctl_nxt = avs_writedata[7:0];
        if (wr && avs_address == OFS_DATA && st_r == S_IDLE)
        begin
            tx_nxt = avs_writedata[7:0];
            bf_nxt = 1'b1;
        end
        // RQ17 disable ends transfer
        if (!ctl_nxt[CTL_EN])
        begin
            st_nxt = S_IDLE;
            sda_nxt = 1'b1;
            scl_nxt = 1'b1;
            bf_nxt = 1'b0;
        end
    end

    // Status flags: set beats a simultaneous software clear
    always_comb
    begin
        s_nxt = s_r;
        p_nxt = p_r;
        bcl_nxt = bcl_r;
        evt_nxt = evt_r;
        // RQ20 sticky collision flag
        if (wr && avs_address == OFS_CLR && avs_writedata[ST_BCL])
            bcl_nxt = 1'b0;
        if (wr && avs_address == OFS_CLR && avs_writedata[ST_EVT])
            evt_nxt = 1'b0;
        if (collide)
            bcl_nxt = 1'b1;
        if (start_seen)
        begin
            s_nxt = 1'b1;
            p_nxt = 1'b0;
        end
        // RQ7 stop raises event
        if (stop_seen)
        begin
            p_nxt = 1'b1;
            s_nxt = 1'b0;
            evt_nxt = 1'b1;
        end
        // RQ18 clear on disable
        if (!en)
        begin
            s_nxt = 1'b0;
            p_nxt = 1'b0;
        end
    end

    // Avalon slave: one wait cycle, read data registered with the answer
    always_comb
    begin
        ack_nxt = (avs_read | avs_write) & ~ack_r;
        rd_nxt = rd_r;
        if (rd)
        begin
            case (avs_address)
                OFS_CTRL: rd_nxt = {24'h000000, ctl_r};
                OFS_STAT: rd_nxt = {25'h0000000, (st_r != S_IDLE), bus_free, evt_r,
                    bcl_r, p_r, s_r, bf_r};
                OFS_DATA: rd_nxt = {24'h000000, rx_r};
                default: rd_nxt = UNMAPPED_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        // RQ17 reset disables
        if (!arst_n)
        begin
            st_r <= S_IDLE;
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            cnt_r <= 8'h00;
            ctl_r <= 8'h00;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            bit_r <= 4'h0;
            sda_r <= 1'b1;
            scl_r <= 1'b1;
            bf_r <= 1'b0;
            s_r <= 1'b0;
            p_r <= 1'b0;
            bcl_r <= 1'b0;
            evt_r <= 1'b0;
            rd_r <= RESET_WORD;
            ack_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            scl_s_r <= scl_s_nxt;
            sda_s_r <= sda_s_nxt;
            scl_f_r <= scl_f_nxt;
            sda_f_r <= sda_f_nxt;
            cnt_r <= cnt_nxt;
            ctl_r <= ctl_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            bit_r <= bit_nxt;
            sda_r <= sda_nxt;
            scl_r <= scl_nxt;
            bf_r <= bf_nxt;
            s_r <= s_nxt;
            p_r <= p_nxt;
            bcl_r <= bcl_nxt;
            evt_r <= evt_nxt;
            rd_r <= rd_nxt;
            ack_r <= ack_nxt;
        end
    end

    // RQ19 open-drain pins
    assign bus.sda_o_ctl = 1'b0;
    assign bus.sda_oe_ctl = ~sda_r;
    assign bus.scl_o_ctl = 1'b0;
    assign bus.scl_oe_ctl = ~scl_r;
    assign avs_readdata = rd_r;
    assign avs_waitrequest = ~ack_r;
endmodule // twi_arb_master

// ### src/arb_pkg.sv
// Shared constants for the multi-master two-wire arbitration ends
package arb_pkg;
    // Clock rate and bus bit timing
    localparam int CORE_CLK_MHZ = 100;
    localparam int HALF_BIT_NS = 1250;
    localparam int HALF_BIT_CYC = (HALF_BIT_NS * CORE_CLK_MHZ) / 1000;
    localparam logic [7:0] BAUD_RELOAD = 8'(HALF_BIT_CYC);
    localparam logic [7:0] BAUD_ZERO = 8'h00;
    // Cycles from releasing a line until the pin filter shows it high
    localparam logic [7:0] FILT_SETTLE = 8'h04;
    // Avalon register offsets (word addresses) of the controller
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h1;
    localparam logic [3:0] OFS_DATA = 4'h2;
    localparam logic [3:0] OFS_CLR = 4'h3;
    // Control field positions (serial_control_two and enable)
    localparam int CTL_START = 0;
    localparam int CTL_RSTART = 1;
    localparam int CTL_STOP = 2;
    localparam int CTL_ACK = 3;
    localparam int CTL_ACKDT = 4;
    localparam int CTL_EN = 7;
    // Status field positions (serial_port_status and event flags)
    localparam int ST_BF = 0;
    localparam int ST_S = 1;
    localparam int ST_P = 2;
    localparam int ST_BCL = 3;
    localparam int ST_EVT = 4;
    localparam int ST_FREE = 5;
    localparam int ST_BUSY = 6;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000;
endpackage

// ### src/twi_bus_if.sv
// Open-drain two-wire bus joining the controller and the far party
`timescale 1ns/1ns
interface twi_bus_if;
    logic scl_o_ctl;
    logic scl_oe_ctl;
    logic sda_o_ctl;
    logic sda_oe_ctl;
    logic scl_o_far;
    logic scl_oe_far;
    logic sda_o_far;
    logic sda_oe_far;
    logic scl_i;
    logic sda_i;
    // Wired-AND: any enabled driver pulls low, else pull-up gives high
    assign scl_i = ~((scl_oe_ctl & ~scl_o_ctl) | (scl_oe_far & ~scl_o_far));
    assign sda_i = ~((sda_oe_ctl & ~sda_o_ctl) | (sda_oe_far & ~sda_o_far));
    modport ctl (input scl_i, input sda_i, output scl_o_ctl, output scl_oe_ctl,
        output sda_o_ctl, output sda_oe_ctl);
    modport far (input scl_i, input sda_i, output scl_o_far, output scl_oe_far,
        output sda_o_far, output sda_oe_far);
endinterface

// ### src/twi_far_end.sv
// Far party: a simple byte receiver that acknowledges or drives a forced bit
`timescale 1ns/1ns
module twi_far_end
(
    input wire logic core_clk,
    input wire logic arst_n,
    twi_bus_if.far bus,
    input wire logic ack_en,
    input wire logic force_low,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    import arb_pkg::*;
    logic [2:0] scl_s_r, scl_s_nxt, sda_s_r, sda_s_nxt;
    logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, rx_byte_r, rx_byte_nxt;
    logic act_r, act_nxt, ack_r, ack_nxt, drv_r, drv_nxt, vld_r, vld_nxt;
    logic scl_rise, scl_fall;

    // Filtered inputs: change taken when second and third stages agree
    always_comb
    begin
        scl_s_nxt = {scl_s_r[1:0], bus.scl_i};
        sda_s_nxt = {sda_s_r[1:0], bus.sda_i};
        scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
        sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
    end
    assign scl_rise = scl_f_nxt & ~scl_f_r;
    assign scl_fall = ~scl_f_nxt & scl_f_r;

    // Receiver: Start arms it, eight bits shift in, ninth clock acknowledges
    always_comb
    begin
        act_nxt = act_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ack_nxt = ack_r;
        rx_byte_nxt = rx_byte_r;
        vld_nxt = 1'b0;
        if (scl_f_r && sda_f_r && !sda_f_nxt)
        begin
            act_nxt = 1'b1;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
        end
        else if (scl_f_r && !sda_f_r && sda_f_nxt)
        begin
            act_nxt = 1'b0;
            ack_nxt = 1'b0;
        end
        else if (act_r && scl_rise && cnt_r < 4'h8)
        begin
            sh_nxt = {sh_r[6:0], sda_f_r};
            cnt_nxt = cnt_r + 4'h1;
        end
        else if (act_r && scl_fall)
        begin
            if (cnt_r == 4'h8)
            begin
                ack_nxt = ack_en;
                rx_byte_nxt = sh_r;
                vld_nxt = 1'b1;
                cnt_nxt = 4'h9;
            end
            else if (cnt_r == 4'h9)
            begin
                ack_nxt = 1'b0;
                cnt_nxt = 4'h0;
            end
        end
    end

    // RQ3 change on low
    // A new pull starts only while SCL is seen low; letting go while SCL is high
    // is a Stop by this party, which hands back a bus that it has won
    assign drv_nxt = scl_f_r ? (drv_r & (ack_r | force_low)) : (ack_r | force_low);

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rx_byte_r <= 8'h00;
            act_r <= 1'b0;
            ack_r <= 1'b0;
            drv_r <= 1'b0;
            vld_r <= 1'b0;
        end
        else
        begin
            scl_s_r <= scl_s_nxt;
            sda_s_r <= sda_s_nxt;
            scl_f_r <= scl_f_nxt;
            sda_f_r <= sda_f_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rx_byte_r <= rx_byte_nxt;
            act_r <= act_nxt;
            ack_r <= ack_nxt;
            drv_r <= drv_nxt;
            vld_r <= vld_nxt;
        end
    end

    // RQ19 open drain
    assign bus.sda_o_far = 1'b0;
    assign bus.sda_oe_far = drv_r;
    assign bus.scl_o_far = 1'b0;
    assign bus.scl_oe_far = 1'b0;
    assign rx_byte = rx_byte_r;
    assign rx_valid = vld_r;
endmodule // twi_far_end

// ### dv/twi_arb_assertions.sv
// Concurrent checks on the two-wire bus between the controller and the far party
`timescale 1ns/1ns
module twi_arb_checker
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_o_ctl,
    input wire logic scl_oe_ctl,
    input wire logic sda_o_ctl,
    input wire logic sda_oe_ctl,
    input wire logic sda_oe_far,
    input wire logic scl_i,
    input wire logic sda_i
);
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic scl_d_r;
    logic sda_d_r;
    logic lines_free;
    logic in_byte;

    // Bit position in a byte; an SDA edge while SCL is high restarts it.
    // The clock after an ack may be a Stop, so it is parked at 10 and not checked.
    always_comb
    begin
        bit_cnt_nxt = bit_cnt_r;
        if (scl_i && scl_d_r && (sda_i != sda_d_r))
        begin
            bit_cnt_nxt = 4'h0;
        end
        else if (scl_i && !scl_d_r)
        begin
            if (bit_cnt_r == 4'h9)
                bit_cnt_nxt = 4'hA;
            else if (bit_cnt_r == 4'hA)
                bit_cnt_nxt = 4'h2;
            else
                bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
    end

    // Registers of the bit tracker
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bit_cnt_r <= 4'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_nxt;
            scl_d_r <= scl_i;
            sda_d_r <= sda_i;
        end
    end

    // Ack bit (9th) is excluded: the far party owns SDA there
    assign lines_free = !scl_oe_ctl && !sda_oe_ctl;
    assign in_byte = (bit_cnt_r != 4'h0) && (bit_cnt_r < 4'h9);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    open_drain_a: assert property (!scl_o_ctl && !sda_o_ctl)
        else $error("driver level not low");
    reset_release_a: assert property ($rose(arst_n) |-> lines_free)
        else $error("lines held after reset");
    start_wait_a: assert property ($rose(sda_oe_ctl) && scl_i |-> $past(lines_free, 100))
        else $error("start without released count");
    start_hold_a: assert property ($rose(sda_oe_ctl) && scl_i |-> ##[115:135] $rose(scl_oe_ctl))
        else $error("clock not pulled after second count");
    collision_release_a: assert property ((in_byte && scl_i && !sda_oe_ctl && sda_oe_far)[*2]
        |-> ##[0:8] lines_free[*8])
        else $error("collision did not release lines");
    data_stable_a: assert property (in_byte && $changed(sda_oe_ctl) |-> !scl_i)
        else $error("data moved while clock high");
    hold_time_a: assert property ($rose(scl_oe_ctl) |-> $stable(sda_oe_ctl))
        else $error("data moved on clock fall");
    setup_time_a: assert property ($fell(scl_oe_ctl)
        |-> $stable(sda_oe_ctl) && ($past(sda_oe_ctl) == $past(sda_oe_ctl, 2)))
        else $error("data not set up before clock release");
endmodule // twi_arb_checker

// ### dv/i2c_master_bus_arbitration_bench.sv
// Self-checking bench joining the controller and the far party over one bus
`timescale 1ns/1ns
module i2c_master_bus_arbitration_bench;
    import arb_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] EN = 32'h0000_0001 << CTL_EN;
    localparam logic [31:0] REQ = 32'h0000_000F;
    localparam logic [31:0] FULL = 32'h0000_0001;
    localparam logic [31:0] SB = 32'h0000_0001 << ST_S;
    localparam logic [31:0] PB = 32'h0000_0001 << ST_P;
    localparam logic [31:0] BCL = 32'h0000_0001 << ST_BCL;
    localparam logic [31:0] EVT = 32'h0000_0001 << ST_EVT;
    localparam logic [31:0] FREE = 32'h0000_0001 << ST_FREE;
    localparam logic [31:0] BUSY = 32'h0000_0001 << ST_BUSY;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ack_en = 1'b1;
    logic force_low = 1'b0;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [7:0] last_rx = 8'h00;
    logic [31:0] rd_data;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;

    twi_bus_if bus();
    twi_arb_master twi_arb_master_i (.core_clk(core_clk), .arst_n(arst_n), .bus(bus),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    twi_far_end twi_far_end_i (.core_clk(core_clk), .arst_n(arst_n), .bus(bus),
        .ack_en(ack_en), .force_low(force_low), .rx_byte(rx_byte), .rx_valid(rx_valid));
    twi_arb_checker twi_arb_checker_i (.core_clk(core_clk), .arst_n(arst_n),
        .scl_o_ctl(bus.scl_o_ctl), .scl_oe_ctl(bus.scl_oe_ctl), .sda_o_ctl(bus.sda_o_ctl),
        .sda_oe_ctl(bus.sda_oe_ctl), .sda_oe_far(bus.sda_oe_far), .scl_i(bus.scl_i),
        .sda_i(bus.sda_i));

    // 100 MHz clock; a cycle ceiling cuts a hang short
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            complete_run();
        end
    end

    // Keep the last byte the far party received
    always @(posedge core_clk)
    begin
        if (rx_valid === 1'b1)
            last_rx <= rx_byte;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon cycle; held until waitrequest is sampled low at an edge
    task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge core_clk);
        end
        rd_data = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        bus_op(1'b0, a, 32'h0);
        check32(rd_data & m, e);
    endtask

    // Poll until the masked field shows the wanted value, then compare
    task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        bus_op(1'b0, a, 32'h0);
        while ((rd_data & m) !== e && n < 3000)
        begin
            bus_op(1'b0, a, 32'h0);
            n++;
        end
        check32(rd_data & m, e);
    endtask

    task automatic seq(input logic [31:0] req);
        bus_op(1'b1, OFS_CTRL, EN | req);
        poll(OFS_CTRL, REQ, 32'h0);
    endtask

    task automatic send(input logic [7:0] b);
        bus_op(1'b1, OFS_DATA, {24'h0, b});
        poll(OFS_STAT, BUSY, 32'h0);
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd_chk(OFS_CTRL, ALL, RESET_WORD);
        rd_chk(4'hF, ALL, UNMAPPED_WORD);
        bus_op(1'b1, OFS_CTRL, EN);
        rd_chk(OFS_STAT, ALL, FREE);
        seq(32'h0000_0001 << CTL_START);
        rd_chk(OFS_STAT, SB | PB | FREE, SB);
        send(8'hA5);
        check32({24'h0, last_rx}, 32'h0000_00A5);
        seq(32'h0000_0001 << CTL_STOP);
        rd_chk(OFS_STAT, SB | PB | FREE, PB | FREE);
        // Far party forces a low during a byte of ones
        seq(32'h0000_0001 << CTL_START);
        force_low <= 1'b1;
        send(8'hFF);
        rd_chk(OFS_STAT, BCL | FULL, BCL);
        bus_op(1'b1, OFS_CLR, 32'h0);
        rd_chk(OFS_STAT, BCL, BCL);
        // SDA is still held low, so a Start request must collide at once
        bus_op(1'b1, OFS_CLR, BCL);
        seq(32'h0000_0001 << CTL_START);
        rd_chk(OFS_STAT, BCL | BUSY, BCL);
        // Far party lets go while SCL is high: a Stop the controller must see
        force_low <= 1'b0;
        poll(OFS_STAT, EVT | FREE, EVT | FREE);
        bus_op(1'b1, OFS_CLR, BCL | EVT);
        rd_chk(OFS_STAT, BCL | EVT, 32'h0);
        // Restart with a Start; the byte must go out whole
        seq(32'h0000_0001 << CTL_START);
        send(8'h5A);
        check32({24'h0, last_rx}, 32'h0000_005A);
        seq(32'h0000_0001 << CTL_STOP);
        rd_chk(OFS_STAT, EVT, EVT);
        bus_op(1'b1, OFS_CTRL, 32'h0);
        rd_chk(OFS_STAT, SB | PB, 32'h0);
        // Second reset in mid-run
        arst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd_chk(OFS_CTRL, ALL, RESET_WORD);
        complete_run();
    end
endmodule // i2c_master_bus_arbitration_bench
